// ### dv/field_sensor_model.sv
// field sensors: drive the eight comparator levels
// assumes the bench sets the wanted field level per channel
`default_nettype none
module field_sensor_model (
	input wire logic sys_clk_in,
	input wire logic [7:0] level_in,
	output logic [7:0] comparator_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// comparator follows the field one clock later
	always @(posedge sys_clk_in)
		comparator_out <= level_in;
endmodule
`default_nettype wire

// ### dv/octal_input_config_glitch_filter_chk.sv
// checker for the octal input front end
// assumes binding to the top module, one clock
`default_nettype none
`include "input_filter_defs.vh"
module octal_input_chk (
	input wire sys_clk_in,
	input wire rst_in,
	input wire latch_n_in,
	input wire cs_n_in,
	input wire [8*`CFG_W-1:0] channel_config_reg_in,
	input wire current_reference_pin_short_in,
	input wire second_fault_reg_read_in,
	input wire [7:0] input_state_reg_out,
	input wire [7:0] channel_state_out,
	input wire reference_short_flag_out,
	input wire [7:0] sink_enable_out,
	input wire [7:0] threshold_high_out,
	input wire [8*3-1:0] mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [1:0] cur = channel_config_reg_in[1:0];
	wire pol = channel_config_reg_in[2];
	wire stb = latch_n_in & cs_n_in;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// ***
	// channel 0 decode, capture, fault, filter
	// ***
	a_mode_type13: assert property (cur == 2'h1 && channel_config_reg_in[3]
		|-> mode_out[2:0] == 3'h1 && threshold_high_out[0])
		else $error("type 1/3 decode wrong");
	a_mode_type2: assert property (cur == 2'h2
		|-> mode_out[2:0] == 3'h2 && sink_enable_out[0])
		else $error("type 2 decode wrong");
	a_mode_fixed: assert property ((cur == 2'h0 || cur == 2'h3)
		|-> !sink_enable_out[0] && !threshold_high_out[0] && mode_out[2:0]
		== (pol ? 3'h0 : (cur == 2'h0 ? 3'h4 : 3'h3)))
		else $error("fixed mode decode wrong");
	a_capture_time: assert property (!$stable(input_state_reg_out)
		|-> !$past(stb, 3) && $past(stb, 4))
		else $error("capture without strobe edge");
	a_fault_set: assert property (current_reference_pin_short_in [*4]
		|=> reference_short_flag_out)
		else $error("short flag not set");
	a_fault_sticky: assert property (reference_short_flag_out
		&& !second_fault_reg_read_in |=> reference_short_flag_out)
		else $error("short flag lost");
	a_tick_spacing: assert property (!$stable(channel_state_out)
		|=> $stable(channel_state_out) [*8])
		else $error("state moved off tick");
	a_reset_clear: assert property (disable iff (1'b0) rst_in
		|=> channel_state_out == 8'h00 && input_state_reg_out == 8'h00
		&& !reference_short_flag_out)
		else $error("reset state wrong");
	c_fault: cover property ($rose(reference_short_flag_out));
	c_rise: cover property ($rose(channel_state_out[0]));
	c_capture: cover property (!$stable(input_state_reg_out));
endmodule
bind octal_input_config_glitch_filter octal_input_chk chk (.*);
`default_nettype wire

// ### dv/test_octal_input_config_glitch_filter.sv
// bench for the octal input front end
// assumes the design tree and the field sensor model
`default_nettype none
module test_octal_input_config_glitch_filter;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [23:0] MT = 24'h08_868C;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] lvl = 8'h00;
	logic ln = 1'b1;
	logic cs = 1'b1;
	logic [63:0] cfg = 64'h0;
	logic sh = 1'b0;
	logic rd = 1'b0;
	wire [7:0] cmp, ist, cst, sink, thr;
	wire flag;
	wire [23:0] mode;
	integer fail_count = 0;
	integer check_count = 0;
	integer cyc = 0;
	field_sensor_model sensors (.sys_clk_in, .level_in(lvl),
		.comparator_out(cmp));
	octal_input_config_glitch_filter dut (.sys_clk_in, .rst_in,
		.comparator_in(cmp), .latch_n_in(ln), .cs_n_in(cs),
		.channel_config_reg_in(cfg), .current_reference_pin_short_in(sh),
		.second_fault_reg_read_in(rd), .input_state_reg_out(ist),
		.channel_state_out(cst), .reference_short_flag_out(flag),
		.sink_enable_out(sink), .threshold_high_out(thr), .mode_out(mode));
	initial
		forever #10 sys_clk_in = ~sys_clk_in;
	task close_out;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 40000)
		begin
			fail_count = fail_count + 1;
			close_out;
		end
	end
	task wt(input integer n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task t_modes;
		integer i;
		for (i = 0; i < 8; i++)
		begin
			cfg[7:0] = {4'h0, i[1:0] == 2'h1, i[2:0]};
			wt(1);
			chk(mode[2:0], MT[i*3+:3]);
			chk(sink[0], ^i[1:0]);
			chk(thr[0], i[1:0] == 2'h1);
		end
	endtask
	task t_filter;
		cfg = 64'h0000_0000_0050_3010;
		lvl = 8'h07;
		wt(2450);
		chk(cst[2:0], 3'h0);
		wt(150);
		chk(cst[2:0], 3'h1);
		wt(2350);
		chk(cst[2:0], 3'h1);
		wt(150);
		chk(cst[2:0], 3'h3);
		wt(14850);
		chk(cst[2:0], 3'h3);
		wt(150);
		chk(cst[2:0], 3'h7);
		lvl = 8'h06;
		wt(150);
		lvl = 8'h07;
		wt(300);
		chk(cst[0], 1'b1);
		lvl = 8'h00;
		wt(2450);
		chk(cst[0], 1'b1);
		wt(150);
		chk(cst[0], 1'b0);
	endtask
	task t_bypass;
		cfg = 64'h0000_0000_0400_0000;
		wt(120);
		chk(cst[4:3], 2'h1);
		lvl = 8'h18;
		wt(120);
		chk(cst[4:3], 2'h2);
	endtask
	task t_capture;
		cfg = 64'h0;
		lvl = 8'hA5;
		wt(120);
		ln = 1'b0;
		wt(6);
		chk(ist, 8'hA5);
		lvl = 8'h5A;
		wt(120);
		cs = 1'b0;
		wt(6);
		chk(ist, 8'hA5);
		ln = 1'b1;
		cs = 1'b1;
		wt(3);
		cs = 1'b0;
		wt(6);
		chk(ist, 8'h5A);
		cs = 1'b1;
	endtask
	task t_fault;
		sh = 1'b1;
		wt(8);
		chk(flag, 1'b1);
		sh = 1'b0;
		wt(8);
		chk(flag, 1'b1);
		rd = 1'b1;
		wt(1);
		rd = 1'b0;
		wt(4);
		chk(flag, 1'b0);
		sh = 1'b1;
		wt(8);
		rd = 1'b1;
		wt(1);
		rd = 1'b0;
		wt(2);
		chk(flag, 1'b1);
		sh = 1'b0;
	endtask
	initial
	begin
		wt(10);
		rst_in = 1'b0;
		wt(2);
		chk(cst, 8'h00);
		chk(ist, 8'h00);
		chk(flag, 1'b0);
		t_modes;
		t_filter;
		t_bypass;
		t_capture;
		t_fault;
		close_out;
	end
endmodule
`default_nettype wire

// ### rtl/channel_filter.v
// one channel: mode decode, polarity, glitch filter with bypass
// assumes a one-cycle tick strobe at 1 MHz and a synchronised comparator input
`default_nettype none
`include "input_filter_defs.vh"

module channel_filter (
	// clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// tick and data
	input wire tick_in,
	input wire cmp_in,
	input wire [`CFG_W-1:0] cfg_in,
	// results
	output reg state_out,
	output reg [2:0] mode_out,
	output reg sink_on_out,
	output reg threshold_high_out
);

	// ****************************************
	// delay lookup
	// ****************************************
	function [`FLT_CNT_W-1:0] upper_limit;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: upper_limit = `DLY_US_0;
				3'h1: upper_limit = `DLY_US_1;
				3'h2: upper_limit = `DLY_US_2;
				3'h3: upper_limit = `DLY_US_3;
				3'h4: upper_limit = `DLY_US_4;
				3'h5: upper_limit = `DLY_US_5;
				3'h6: upper_limit = `DLY_US_6;
				default: upper_limit = `DLY_US_7;
			endcase
		end
	endfunction

	wire [1:0] curr = cfg_in[`CFG_CURR_HI:`CFG_CURR_LO];
	wire pol = cfg_in[`CFG_POL];
	wire high_threshold_sel = cfg_in[`CFG_HIGH_THRESHOLD_SEL];
	wire filter_enable_bit = cfg_in[`CFG_FILTER_ENABLE_BIT];
	wire [2:0] dsel = cfg_in[`CFG_DLY_HI:`CFG_DLY_LO];
	wire [`FLT_CNT_W-1:0] lim = upper_limit(dsel);
	wire on_level = cmp_in ^ pol;

	reg [`FLT_CNT_W-1:0] cnt_r;
	reg [`FLT_CNT_W-1:0] cnt_nxt;
	reg filt_r;
	reg filt_nxt;

	// ****************************************
	// mode decode
	// ****************************************
	always @*
	begin
		threshold_high_out = 1'b0;
		sink_on_out = 1'b0;
		case (curr)
			`CURR_1X:
			begin
				mode_out = `MODE_TYPE13;
				sink_on_out = 1'b1;
				threshold_high_out = high_threshold_sel;
			end
			`CURR_3X:
			begin
				mode_out = `MODE_TYPE2;
				sink_on_out = 1'b1;
				threshold_high_out = high_threshold_sel;
			end
			`CURR_TTL:
				mode_out = pol ? `MODE_HIZ : `MODE_TTL;
			default:
				mode_out = pol ? `MODE_HIZ : `MODE_HTL;
		endcase
	end

	// ****************************************
	// up-down counter
	// ****************************************
	always @*
	begin
		cnt_nxt = cnt_r;
		filt_nxt = filt_r;
		if (tick_in)
		begin
			if (on_level)
			begin
				if (cnt_r < lim)
					cnt_nxt = cnt_r + 1'b1;
				else
					cnt_nxt = lim;
			end
			else if (cnt_r != {`FLT_CNT_W{1'b0}})
				cnt_nxt = (cnt_r > lim) ? lim : cnt_r - 1'b1;
			if (cnt_nxt >= lim)
				filt_nxt = 1'b1;
			else if (cnt_nxt == {`FLT_CNT_W{1'b0}})
				filt_nxt = 1'b0;
		end
	end

	always @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cnt_r <= {`FLT_CNT_W{1'b0}};
			filt_r <= 1'b0;
			state_out <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			filt_r <= filt_nxt;
			if (tick_in)
				state_out <= filter_enable_bit ? filt_nxt : on_level;
		end
	end

endmodule
`default_nettype wire

// ### rtl/input_filter_defs.vh
// constants for the octal input front end: timing, fields, delays
// assumes a 50 MHz system clock and a 1 MHz filter tick derived from it
//
// Behaviour
// - capture all eight channel states together on latch or chip select.
// - capture on the falling edge into the input state register.
// - polarity 0 reports high as 1; polarity 1 reports low as 1.
// - current sink or source can be switched off, comparator stays on.
// - current field 01 with high threshold 1 selects Type 1/3.
// - current field 10 with high threshold 0 selects Type 2.
// - fields 00 and 11 give HTL, TTL or high-impedance; threshold ignored.
// - set reference short flag when the reference resistor is too small.
// - each channel has its own filter, enabled or bypassed per channel.
// - comparator outputs are sampled and latched at 1 MHz.
// - each channel selects one of eight delays from 50 us to 20 ms.
// - saturating up-down counter at 1 MHz, up on high, down on low.
// - output rises only at upper limit, falls only at lower limit.
// - lower limit is zero for every delay.
// - upper limit equals the 1 MHz ticks in the selected delay.
// - bypassed channel sampled at 1 MHz, within one microsecond of capture.
`ifndef INPUT_FILTER_DEFS_VH
`define INPUT_FILTER_DEFS_VH

// ****************************************
// timing
// ****************************************
// 50 system clocks per 1 MHz tick
`define TICK_LAST 6'h31
`define TICK_CNT_W 6

// ****************************************
// filter upper limits in 1 MHz ticks
// ****************************************
`define DLY_US_0 15'h0032
`define DLY_US_1 15'h0064
`define DLY_US_2 15'h0190
`define DLY_US_3 15'h0320
`define DLY_US_4 15'h0640
`define DLY_US_5 15'h0C80
`define DLY_US_6 15'h3200
`define DLY_US_7 15'h4E20
`define FLT_CNT_W 15

// ****************************************
// channel config field layout
// ****************************************
`define CFG_W 8
`define CFG_CURR_LO 0
`define CFG_CURR_HI 1
`define CFG_POL 2
`define CFG_HIGH_THRESHOLD_SEL 3
`define CFG_FILTER_ENABLE_BIT 4
`define CFG_DLY_LO 5
`define CFG_DLY_HI 7
`define CFG_RESET 8'h00

// ****************************************
// current field and mode codes
// ****************************************
`define CURR_OFF 2'h0
`define CURR_1X 2'h1
`define CURR_3X 2'h2
`define CURR_TTL 2'h3
`define MODE_HIZ 3'h0
`define MODE_TYPE13 3'h1
`define MODE_TYPE2 3'h2
`define MODE_TTL 3'h3
`define MODE_HTL 3'h4

`endif

// ### rtl/octal_input_config_glitch_filter.v
// top: eight channels, 1 MHz tick, simultaneous capture, fault flag
// assumes asynchronous pins for comparators, strobes and reference short
`default_nettype none
`include "input_filter_defs.vh"

module octal_input_config_glitch_filter (
	// clock and reset
	input wire sys_clk_in,
	input wire rst_in,
	// field comparators
	input wire [7:0] comparator_in,
	// capture strobes, active low
	input wire latch_n_in,
	input wire cs_n_in,
	// channel config, eight bytes
	input wire [8*`CFG_W-1:0] channel_config_reg_in,
	// reference resistor monitor and flag clear
	input wire current_reference_pin_short_in,
	input wire second_fault_reg_read_in,
	// results
	output reg [7:0] input_state_reg_out,
	output wire [7:0] channel_state_out,
	output reg reference_short_flag_out,
	output wire [7:0] sink_enable_out,
	output wire [7:0] threshold_high_out,
	output wire [8*3-1:0] mode_out
);

	// ****************************************
	// synchronisers
	// ****************************************
	reg [7:0] cmp_s1_r;
	reg [7:0] cmp_s2_r;
	reg [2:0] strb_s1_r;
	reg [2:0] strb_s2_r;
	reg strobe_prev_r;
	reg [`TICK_CNT_W-1:0] tick_cnt_r;
	reg tick_r;

	always @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cmp_s1_r <= 8'h00;
			cmp_s2_r <= 8'h00;
			strb_s1_r <= 3'h3;
			strb_s2_r <= 3'h3;
		end
		else
		begin
			cmp_s1_r <= comparator_in;
			cmp_s2_r <= cmp_s1_r;
			strb_s1_r <= {current_reference_pin_short_in, cs_n_in, latch_n_in};
			strb_s2_r <= strb_s1_r;
		end
	end

	// ****************************************
	// 1 MHz tick
	// ****************************************
	always @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			tick_cnt_r <= {`TICK_CNT_W{1'b0}};
			tick_r <= 1'b0;
		end
		else if (tick_cnt_r == `TICK_LAST)
		begin
			tick_cnt_r <= {`TICK_CNT_W{1'b0}};
			tick_r <= 1'b1;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// ****************************************
	// channels
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : ch
			channel_filter u_ch (
				.sys_clk_in(sys_clk_in),
				.rst_in(rst_in),
				.tick_in(tick_r),
				.cmp_in(cmp_s2_r[g]),
				.cfg_in(channel_config_reg_in[g*`CFG_W +: `CFG_W]),
				.state_out(channel_state_out[g]),
				.mode_out(mode_out[g*3 +: 3]),
				.sink_on_out(sink_enable_out[g]),
				.threshold_high_out(threshold_high_out[g])
			);
		end
	endgenerate

	// ****************************************
	// simultaneous capture
	// ****************************************
	wire strobe_low = strb_s2_r[0] & strb_s2_r[1];
	wire capture = strobe_prev_r & ~strobe_low;

	always @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			strobe_prev_r <= 1'b1;
			input_state_reg_out <= 8'h00;
		end
		else
		begin
			strobe_prev_r <= strobe_low;
			if (capture)
				input_state_reg_out <= channel_state_out;
		end
	end

	// ****************************************
	// reference short flag
	// ****************************************
	always @(posedge sys_clk_in)
	begin
		if (rst_in)
			reference_short_flag_out <= 1'b0;
		else if (strb_s2_r[2])
			reference_short_flag_out <= 1'b1;
		else if (second_fault_reg_read_in)
			reference_short_flag_out <= 1'b0;
	end

endmodule
`default_nettype wire
